// File: psdt_host.sv
`timescale 1ns/1ps
// Host software model: a register port master that never overlaps strobes
module psdt_host (
  // Clock
  input wire logic clock,
  // Register port
  output logic [11:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd
);
  // Quiet bus at time zero
  initial begin
    addr = 12'h000;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One write cycle, launched just after an edge
  task automatic put(input logic [11:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clock);
  endtask : put
  // One read cycle; data are taken by the bench in the next cycle
  task automatic get(input logic [11:0] a);
    addr <= a;
    wdata <= ~wdata; // Released data do not hold their last value
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clock);
  endtask : get
  // Idle cycles with both strobes low
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    wdata <= ~wdata;
    repeat (n) @(posedge clock);
  endtask : idle
endmodule : psdt_host

// File: psdt_pkg.sv
package psdt_pkg;
  // Structure geometry in bytes, then slot and word counts
  localparam int unsigned STRUCT_BYTES = 4096;
  localparam int unsigned SLOT_BYTES = 32;
  localparam int unsigned SLOT_ZERO_BASE = 2048;
  localparam int unsigned SLOT_ZERO_LAST = 2079;
  localparam int unsigned SLOT_ELEVEN_BASE = 2400;
  localparam int unsigned SLOT_THIRTY_ONE_LAST = 3071;
  localparam int unsigned VENDOR_BASE = 3072;
  localparam int unsigned VENDOR_LAST = 4095;
  localparam int unsigned NUM_SLOTS = 32;
  localparam int unsigned WORDS_PER_SLOT = 8;
  localparam int unsigned VENDOR_WORDS = 256;

  // Register port byte offsets (word index = byte address / 4)
  localparam logic [11:0] OFS_SLOT_BASE = 12'h800;
  localparam logic [11:0] OFS_VENDOR_BASE = 12'hC00;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;

  // Reset values
  localparam logic [5:0] NUM_STATES_RESET = 6'h01;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Descriptor field positions
  localparam int unsigned POS_WL = 120;
  localparam int unsigned POS_WT = 112;
  localparam int unsigned POS_RL = 104;
  localparam int unsigned POS_RT = 96;
  localparam int unsigned POS_LEAVE = 64;
  localparam int unsigned POS_ENTER = 32;
  localparam int unsigned POS_POWER = 0;

  // One descriptor as held by the block
  typedef struct packed {
    logic [4:0] write_latency_rank;
    logic [4:0] write_throughput_rank;
    logic [4:0] read_latency_rank;
    logic [4:0] read_throughput_rank;
    logic [31:0] leave_state_latency_us;
    logic [31:0] enter_state_latency_us;
    logic [15:0] peak_power_centiwatt;
  } psdt_desc_t;
endpackage : psdt_pkg

// File: psdt_table.sv
`timescale 1ns/1ps
module psdt_table #(
  parameter int unsigned NUM_SLOTS = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Status
  output logic [5:0] num_states,
  output logic rank_error
);

  // Word index decode
  logic [9:0] widx;
  logic in_slots;
  logic in_vendor;
  logic [4:0] slot_sel;
  logic [2:0] word_sel;
  assign widx = addr[11:2];
  assign in_slots = (addr >= psdt_pkg::OFS_SLOT_BASE) && (addr < psdt_pkg::OFS_VENDOR_BASE);
  assign in_vendor = (addr >= psdt_pkg::OFS_VENDOR_BASE);
  assign slot_sel = widx[7:3];
  assign word_sel = widx[2:0];

  // Descriptor storage and vendor area storage
  psdt_pkg::psdt_desc_t desc_reg [psdt_pkg::NUM_SLOTS];
  logic [31:0] vendor_reg [psdt_pkg::VENDOR_WORDS];
  logic [5:0] num_states_reg;
  logic [5:0] num_states_next;
  logic rank_error_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Supported state count, slot zero always counted
  always_comb begin
    num_states_next = num_states_reg;
    if (wr && addr == psdt_pkg::OFS_CTRL) begin
      if (wdata == psdt_pkg::ZERO_WORD) begin
        num_states_next = psdt_pkg::NUM_STATES_RESET;
      end else if (wdata > 32'h0000_0020) begin
        num_states_next = 6'h20;
      end else begin
        num_states_next = wdata[5:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      num_states_reg <= psdt_pkg::NUM_STATES_RESET;
    end else begin
      num_states_reg <= num_states_next;
    end
  end

  // Descriptor fields written word by word; reserved bits never stored
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
      always_ff @(posedge clock) begin
        if (!resetn) begin
          desc_reg[g] <= '0;
        end else if (wr && in_slots && slot_sel == 5'(g)) begin
          case (word_sel)
            3'h0: begin
              desc_reg[g].peak_power_centiwatt <= wdata[15:0];
            end
            3'h1: begin
              desc_reg[g].enter_state_latency_us <= wdata;
            end
            3'h2: begin
              desc_reg[g].leave_state_latency_us <= wdata;
            end
            3'h3: begin
              desc_reg[g].read_throughput_rank <= wdata[4:0];
              desc_reg[g].read_latency_rank <= wdata[12:8];
              desc_reg[g].write_throughput_rank <= wdata[20:16];
              desc_reg[g].write_latency_rank <= wdata[28:24];
            end
            default: begin
            end
          endcase
        end
      end
    end
  endgenerate

  // Vendor-defined area storage
  always_ff @(posedge clock) begin
    if (wr && in_vendor) begin
      vendor_reg[widx[7:0]] <= wdata;
    end
  end

  // Rank at or above supported count in a supported slot flags a table error
  logic rank_bad;
  always_comb begin
    rank_bad = 1'b0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (6'(i) < num_states_reg) begin
        if ({1'b0, desc_reg[i].write_latency_rank} >= num_states_reg ||
            {1'b0, desc_reg[i].write_throughput_rank} >= num_states_reg ||
            {1'b0, desc_reg[i].read_latency_rank} >= num_states_reg ||
            {1'b0, desc_reg[i].read_throughput_rank} >= num_states_reg) begin
          rank_bad = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rank_error_reg <= 1'b0;
    end else begin
      rank_error_reg <= rank_bad;
    end
  end

  // Read mux with rank clamping and zero for reserved or absent slots
  psdt_pkg::psdt_desc_t rd_desc;
  function automatic logic [4:0] clamp(input logic [4:0] v, input logic [5:0] n);
    clamp = ({1'b0, v} < n) ? v : 5'(n - 6'h01);
  endfunction : clamp
  always_comb begin
    rd_desc = desc_reg[slot_sel];
    rdata_next = psdt_pkg::ZERO_WORD;
    if (rd) begin
      if (addr == psdt_pkg::OFS_CTRL) begin
        rdata_next = {26'h0, num_states_reg};
      end else if (addr == psdt_pkg::OFS_STATUS) begin
        rdata_next = {31'h0, rank_error_reg};
      end else if (in_vendor) begin
        rdata_next = vendor_reg[widx[7:0]];
      end else if (in_slots && {1'b0, slot_sel} < num_states_reg) begin
        case (word_sel)
          3'h0: rdata_next = {16'h0, rd_desc.peak_power_centiwatt};
          3'h1: rdata_next = rd_desc.enter_state_latency_us;
          3'h2: rdata_next = rd_desc.leave_state_latency_us;
          3'h3: begin
            rdata_next = {3'h0, clamp(rd_desc.write_latency_rank, num_states_reg),
                          3'h0, clamp(rd_desc.write_throughput_rank, num_states_reg),
                          3'h0, clamp(rd_desc.read_latency_rank, num_states_reg),
                          3'h0, clamp(rd_desc.read_throughput_rank, num_states_reg)};
          end
          default: rdata_next = psdt_pkg::ZERO_WORD;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata_reg <= psdt_pkg::ZERO_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign num_states = num_states_reg;
  assign rank_error = rank_error_reg;

  // Checks
  // Reserved descriptor words read zero
  property p_reserved_zero;
    @(posedge clock) disable iff (!resetn)
    (rd && in_slots && word_sel > 3'h3) |=> rdata == 32'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved descriptor word not zero");

  // Gaps between rank fields read zero
  property p_rsvd_bits;
    @(posedge clock) disable iff (!resetn)
    (rd && in_slots && word_sel == 3'h3) |=> (rdata & 32'hE0E0E0E0) == 32'h0;
  endproperty
  a_rsvd_bits: assert property (p_rsvd_bits)
    else $error("reserved rank bits not zero");

  // Upper half of the power word reads zero
  property p_power_hi;
    @(posedge clock) disable iff (!resetn)
    (rd && in_slots && word_sel == 3'h0) |=> rdata[31:16] == 16'h0;
  endproperty
  a_power_hi: assert property (p_power_hi)
    else $error("power word upper half not zero");

  // Read throughput rank below state count
  property p_rank_lt;
    @(posedge clock) disable iff (!resetn)
    (rd && in_slots && word_sel == 3'h3) |=> {1'b0, rdata[4:0]} < $past(num_states_reg);
  endproperty
  a_rank_lt: assert property (p_rank_lt)
    else $error("rank not below state count");

  // Write latency rank below state count
  property p_wl_rank;
    @(posedge clock) disable iff (!resetn)
    (rd && in_slots && word_sel == 3'h3) |=> {1'b0, rdata[28:24]} < $past(num_states_reg);
  endproperty
  a_wl_rank: assert property (p_wl_rank)
    else $error("write latency rank not below state count");

  // Write throughput rank below state count
  property p_wt_rank;
    @(posedge clock) disable iff (!resetn)
    (rd && in_slots && word_sel == 3'h3) |=> {1'b0, rdata[20:16]} < $past(num_states_reg);
  endproperty
  a_wt_rank: assert property (p_wt_rank)
    else $error("write throughput rank not below state count");

  // Read latency rank below state count
  property p_rl_rank;
    @(posedge clock) disable iff (!resetn)
    (rd && in_slots && word_sel == 3'h3) |=> {1'b0, rdata[12:8]} < $past(num_states_reg);
  endproperty
  a_rl_rank: assert property (p_rl_rank)
    else $error("read latency rank not below state count");

  // Unsupported slots read zero
  property p_absent;
    @(posedge clock) disable iff (!resetn)
    (rd && in_slots && {1'b0, slot_sel} >= num_states_reg) |=> rdata == 32'h0;
  endproperty
  a_absent: assert property (p_absent)
    else $error("unsupported slot not zero");

  // Slot zero is always counted
  property p_slot0;
    @(posedge clock) disable iff (!resetn)
    num_states_reg != 6'h00;
  endproperty
  a_slot0: assert property (p_slot0)
    else $error("slot zero not supported");

  // A zero count write keeps slot zero alone
  property p_zero_count;
    @(posedge clock) disable iff (!resetn)
    (wr && addr == psdt_pkg::OFS_CTRL && wdata == 32'h0) |=> num_states_reg == 6'h01;
  endproperty
  a_zero_count: assert property (p_zero_count)
    else $error("zero count write not raised to one");

  // Count never exceeds the slot total
  property p_count_max;
    @(posedge clock) disable iff (!resetn)
    num_states_reg <= 6'h20;
  endproperty
  a_count_max: assert property (p_count_max)
    else $error("state count above slot total");

  // Oversized count writes clamp to the slot total
  property p_clamp_count;
    @(posedge clock) disable iff (!resetn)
    (wr && addr == psdt_pkg::OFS_CTRL && wdata > 32'h20) |=> num_states_reg == 6'h20;
  endproperty
  a_clamp_count: assert property (p_clamp_count)
    else $error("oversized count not clamped");

  // Enter latency word returns the stored value
  property p_enter;
    @(posedge clock) disable iff (!resetn)
    (rd && in_slots && word_sel == 3'h1 && {1'b0, slot_sel} < num_states_reg)
    |=> rdata == $past(rd_desc.enter_state_latency_us);
  endproperty
  a_enter: assert property (p_enter)
    else $error("enter latency mismatch");

  // Leave latency word returns the stored value
  property p_leave;
    @(posedge clock) disable iff (!resetn)
    (rd && in_slots && word_sel == 3'h2 && {1'b0, slot_sel} < num_states_reg)
    |=> rdata == $past(rd_desc.leave_state_latency_us);
  endproperty
  a_leave: assert property (p_leave)
    else $error("leave latency mismatch");

  // Read data stand only after a read strobe
  property p_idle;
    @(posedge clock) disable iff (!resetn)
    !rd |=> rdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data outside read cycle");

  // Unmapped words read zero
  property p_unmapped;
    @(posedge clock) disable iff (!resetn)
    (rd && !in_slots && !in_vendor && addr != psdt_pkg::OFS_CTRL &&
     addr != psdt_pkg::OFS_STATUS) |=> rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped word not zero");

  // Control word returns the state count
  property p_ctrl_rd;
    @(posedge clock) disable iff (!resetn)
    (rd && addr == psdt_pkg::OFS_CTRL) |=> rdata == {26'h0, $past(num_states_reg)};
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("control word mismatch");

  // Status word carries the error flag alone
  property p_status_rd;
    @(posedge clock) disable iff (!resetn)
    (rd && addr == psdt_pkg::OFS_STATUS) |=> rdata == {31'h0, $past(rank_error_reg)};
  endproperty
  a_status_rd: assert property (p_status_rd)
    else $error("status word mismatch");

  // Error flag rises one cycle after a bad rank
  property p_err_set;
    @(posedge clock) disable iff (!resetn)
    rank_bad |=> rank_error_reg;
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("rank error not raised");

  // Error flag falls one cycle after ranks are legal
  property p_err_clear;
    @(posedge clock) disable iff (!resetn)
    !rank_bad |=> !rank_error_reg;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("rank error not cleared");

  // Main scenarios
  c_vendor: cover property (@(posedge clock) disable iff (!resetn) rd && in_vendor);
  c_full: cover property (@(posedge clock) disable iff (!resetn) num_states_reg == 6'h20);
  c_err: cover property (@(posedge clock) disable iff (!resetn) rank_error_reg);
  c_absent: cover property (@(posedge clock) disable iff (!resetn)
    rd && in_slots && {1'b0, slot_sel} >= num_states_reg);
  c_count_clamp: cover property (@(posedge clock) disable iff (!resetn)
    wr && addr == psdt_pkg::OFS_CTRL && wdata > 32'h0000_0020);

endmodule : psdt_table

// File: psdt_table_tb_top.sv
`timescale 1ns/1ps
module psdt_table_tb_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic wr, rd, rd_q, rank_error;
  logic [5:0] num_states;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h1603C918;
  logic [31:0] msk[4] = '{32'h0000FFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h1F1F1F1F};
  logic [31:0] ev[4];
  logic [31:0] wv;
  logic [11:0] base[3] = '{12'h800, 12'h960, 12'hBE0};
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  always #4 clock = ~clock;
  psdt_table u_psdt_table (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .num_states(num_states), .rank_error(rank_error));
  psdt_host u_psdt_host (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic stop_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  // Note an expectation, then read
  task automatic rx(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_psdt_host.get(a);
  endtask : rx
  // Watcher: read data stand in the cycle after the read strobe
  always @(posedge clock) begin
    rd_q <= rd & resetn;
    if (rd_q) begin
      check(rdata, exp_q.pop_front());
    end
  end
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles > 2000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    rd_q = 1'b0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    check({26'h0, num_states}, 32'h1);
    check({31'h0, rank_error}, 32'h0);
    rx(12'h800, 32'h0);
    u_psdt_host.put(12'h000, 32'h20);
    // Slot zero, eleven and thirty-one; reserved words ignored
    for (int s = 0; s < 3; s++) begin
      for (int w = 0; w < 8; w++) begin
        wv = rnd();
        u_psdt_host.put(base[s] + 12'(4 * w), wv);
        if (w < 4) ev[w] = wv & msk[w];
      end
      for (int w = 0; w < 8; w++) begin
        rx(base[s] + 12'(4 * w), (w < 4) ? ev[w] : 32'h0);
      end
    end
    rx(12'h004, 32'h0);
    // Vendor area is plain storage at both ends
    u_psdt_host.put(12'hC00, 32'hA5A5_0001);
    u_psdt_host.put(12'hFFC, 32'h5A5A_FFFE);
    rx(12'hC00, 32'hA5A5_0001);
    rx(12'hFFC, 32'h5A5A_FFFE);
    rx(12'h100, 32'h0);
    // Counts above the slot total clamp to thirty-two
    u_psdt_host.put(12'h000, 32'h0000_0041);
    u_psdt_host.idle(2);
    check({26'h0, num_states}, 32'h20);
    // Count clamps, unsupported slots read zero, ranks clamp
    u_psdt_host.put(12'h000, 32'h0);
    u_psdt_host.idle(2);
    check({26'h0, num_states}, 32'h1);
    u_psdt_host.put(12'h000, 32'h4);
    u_psdt_host.put(12'h80C, 32'h1402_0100);
    u_psdt_host.idle(3);
    check({31'h0, rank_error}, 32'h1);
    rx(12'h80C, 32'h0302_0100);
    rx(12'h004, 32'h1);
    rx(12'h960, 32'h0);
    u_psdt_host.put(12'h80C, 32'h0302_0100);
    u_psdt_host.idle(3);
    check({31'h0, rank_error}, 32'h0);
    u_psdt_host.idle(4);
    check(32'(exp_q.size()), 32'h0);
    stop_test();
  end
endmodule : psdt_table_tb_top
